/* hw/bctl_bus_control_one.v */
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "bctl_defs.vh"

module bctl_bus_control_one (
	// Clock and power-on reset
	input wire clock_i,
	input wire reset_n_i,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// Mode pin and bus state from the controller
	input wire endian_mode_pin_i,
	input wire bus_ack_i,
	input wire standby_i,
	input wire bus_released_i,
	input wire data_pins_idle_i,
	// Pin control
	output wire address_pullup_o,
	output wire data_pullup_o,
	output wire memory_pins_drive_o,
	output wire strobe_pins_drive_o,
	// Area configuration
	output wire little_endian_o,
	output wire [14:0] burst_count_o,
	output wire area2_sdram_o,
	output wire area3_sdram_o,
	output wire memtype_prohibited_o,
	output wire area5_card_space_o,
	output wire area6_card_space_o
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [15:0] bus_control_one_ff;
	reg [15:0] nxt_bus_control_one;
	reg endian_ff;
	reg endian_done_ff;
	reg [1:0] endian_wait_ff;
	reg [2:0] pullup_cnt_ff;
	reg bus_ack_prev_ff;
	reg data_pullup_ff;
	reg memory_drive_ff;
	reg strobe_drive_ff;
	wire endian_pin_sync;

	// ----------------------------------------
	// Endian capture
	// ----------------------------------------
	bctl_sync u_endian_sync (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.async_i(endian_mode_pin_i),
		.sync_o(endian_pin_sync)
	);

	// capture after release
	// Waits for the synchroniser to fill, then freezes the level until next power-on
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			endian_ff <= 1'b0;
			endian_done_ff <= 1'b0;
			endian_wait_ff <= 2'h0;
		end else if (!endian_done_ff) begin
			if (endian_wait_ff == `BCTL_ENDIAN_CAPTURE_DELAY) begin
				endian_ff <= endian_pin_sync;
				endian_done_ff <= 1'b1;
			end else begin
				endian_wait_ff <= endian_wait_ff + 2'h1;
			end
		end
	end
	assign little_endian_o = endian_ff;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	reg aw_held_ff;
	reg [7:0] aw_addr_ff;
	reg w_held_ff;
	reg [31:0] w_data_ff;
	reg [3:0] w_strb_ff;
	reg bvalid_ff;
	reg [1:0] bresp_ff;
	reg rvalid_ff;
	reg [1:0] rresp_ff;
	reg [31:0] rdata_ff;
	wire wr_fire;
	wire wr_hit;
	wire rd_hit;

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	// Address and data may arrive in either order; both are held until paired
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_hit = (aw_addr_ff == `BCTL_OFF_BUS_CONTROL_ONE);
	assign rd_hit = ({s_axi_araddr[7:2], 2'h0} == `BCTL_OFF_BUS_CONTROL_ONE);

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_held_ff <= 1'b0;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `BCTL_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? `BCTL_RESP_OKAY : `BCTL_RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= `BCTL_RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rd_hit ? `BCTL_RESP_OKAY : `BCTL_RESP_SLVERR;
			// captured endian flag, frozen since power-on, shown in bit 11
			rdata_ff <= rd_hit ? {16'h0000, bus_control_one_ff[15:12], endian_ff,
				bus_control_one_ff[10:0]} : 32'h00000000;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// byte-lane write
	always @* begin
		nxt_bus_control_one = bus_control_one_ff;
		if (wr_fire && wr_hit) begin
			if (w_strb_ff[0]) begin
				nxt_bus_control_one[7:0] = w_data_ff[7:0];
			end
			if (w_strb_ff[1]) begin
				nxt_bus_control_one[15:8] = w_data_ff[15:8];
			end
		end
		nxt_bus_control_one = nxt_bus_control_one & `BCTL_WRITABLE_MASK;
	end

	// power-on only
	// Manual reset and standby never reach this flop, so settings survive them
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus_control_one_ff <= `BCTL_RESET_BUS_CONTROL_ONE;
		end else begin
			bus_control_one_ff <= nxt_bus_control_one;
		end
	end

	// ----------------------------------------
	// Pin control
	// ----------------------------------------
	// pull-up window
	// Counts from the rising edge of bus acknowledge only; a held level does not restart it
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus_ack_prev_ff <= 1'b0;
			pullup_cnt_ff <= 3'h0;
		end else begin
			bus_ack_prev_ff <= bus_ack_i;
			if (bus_ack_i && !bus_ack_prev_ff &&
				bus_control_one_ff[`BCTL_BIT_ADDR_PULLUP]) begin
				pullup_cnt_ff <= `BCTL_ADDR_PULLUP_CYCLES;
			end else if (pullup_cnt_ff != 3'h0) begin
				pullup_cnt_ff <= pullup_cnt_ff - 3'h1;
			end
		end
	end
	assign address_pullup_o = (pullup_cnt_ff != 3'h0);
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			data_pullup_ff <= 1'b0;
			memory_drive_ff <= 1'b1;
			strobe_drive_ff <= 1'b1;
		end else begin
			data_pullup_ff <= bus_control_one_ff[`BCTL_BIT_DATA_PULLUP] && data_pins_idle_i;
			memory_drive_ff <= !standby_i ||
				bus_control_one_ff[`BCTL_BIT_STANDBY_FLOAT_MEM];
			strobe_drive_ff <= !(standby_i || bus_released_i) ||
				bus_control_one_ff[`BCTL_BIT_STROBE_FLOAT];
		end
	end
	assign data_pullup_o = data_pullup_ff;
	assign memory_pins_drive_o = memory_drive_ff;
	assign strobe_pins_drive_o = strobe_drive_ff;

	// ----------------------------------------
	// Area decode
	// ----------------------------------------
	wire [5:0] burst_fields;
	assign burst_fields = {
		bus_control_one_ff[`BCTL_AREA6_BURST_HI:`BCTL_AREA6_BURST_LO],
		bus_control_one_ff[`BCTL_AREA5_BURST_HI:`BCTL_AREA5_BURST_LO],
		bus_control_one_ff[`BCTL_AREA0_BURST_HI:`BCTL_AREA0_BURST_LO]};
	// Each slice: 0 for ordinary memory, else the burst length in accesses.
	// Width limits per code are the software's to respect; nothing is blocked here.
	genvar area;
	generate
		for (area = 0; area < 3; area = area + 1) begin : g_burst
			reg [4:0] count;
			always @* begin
				case (burst_fields[2*area+1:2*area])
					`BCTL_BURST_ORDINARY: count = 5'h00;
					`BCTL_BURST_4: count = 5'h04;
					`BCTL_BURST_8: count = 5'h08;
					`BCTL_BURST_16: count = 5'h10;
					default: count = 5'h00;
				endcase
			end
			assign burst_count_o[5*area+4:5*area] = count;
		end
	endgenerate
	// memory type
	// Prohibited codes fall back to ordinary memory and raise a flag
	wire [2:0] memtype;
	wire memtype_both;
	assign memtype = bus_control_one_ff[`BCTL_MEMTYPE_HI:`BCTL_MEMTYPE_LO];
	assign memtype_both = (memtype == `BCTL_MEMTYPE_BOTH_SDRAM);
	assign area2_sdram_o = memtype_both;
	assign area3_sdram_o = memtype_both || (memtype == `BCTL_MEMTYPE_AREA3_SDRAM);
	assign memtype_prohibited_o = !memtype_both && (memtype != `BCTL_MEMTYPE_AREA3_SDRAM) &&
		(memtype != `BCTL_MEMTYPE_ORDINARY);

	assign area5_card_space_o = bus_control_one_ff[`BCTL_BIT_AREA5_CARD];
	assign area6_card_space_o = bus_control_one_ff[`BCTL_BIT_AREA6_CARD];

endmodule

/* hw/bctl_defs.vh */
`ifndef BCTL_DEFS_VH
`define BCTL_DEFS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BCTL_ADDR_W 8
`define BCTL_OFF_BUS_CONTROL_ONE 8'h00
`define BCTL_RESET_BUS_CONTROL_ONE 16'h0000
`define BCTL_WRITABLE_MASK 16'hf7ff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BCTL_BIT_ADDR_PULLUP 15
`define BCTL_BIT_DATA_PULLUP 14
`define BCTL_BIT_STANDBY_FLOAT_MEM 13
`define BCTL_BIT_STROBE_FLOAT 12
`define BCTL_BIT_ENDIAN 11
`define BCTL_AREA0_BURST_HI 10
`define BCTL_AREA0_BURST_LO 9
`define BCTL_AREA5_BURST_HI 8
`define BCTL_AREA5_BURST_LO 7
`define BCTL_AREA6_BURST_HI 6
`define BCTL_AREA6_BURST_LO 5
`define BCTL_MEMTYPE_HI 4
`define BCTL_MEMTYPE_LO 2
`define BCTL_BIT_AREA5_CARD 1
`define BCTL_BIT_AREA6_CARD 0

// ----------------------------------------
// Encodings
// ----------------------------------------
`define BCTL_BURST_ORDINARY 2'h0
`define BCTL_BURST_4 2'h1
`define BCTL_BURST_8 2'h2
`define BCTL_BURST_16 2'h3
`define BCTL_MEMTYPE_ORDINARY 3'h0
`define BCTL_MEMTYPE_AREA3_SDRAM 3'h2
`define BCTL_MEMTYPE_BOTH_SDRAM 3'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define BCTL_ADDR_PULLUP_CYCLES 3'h4
`define BCTL_ENDIAN_CAPTURE_DELAY 2'h2

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define BCTL_RESP_OKAY 2'h0
`define BCTL_RESP_SLVERR 2'h2

`endif

/* hw/bctl_sync.v */
`timescale 1ns/1ps

module bctl_sync (
	// Clock and reset
	input wire clock_i,
	input wire reset_n_i,
	// Level in and out
	input wire async_i,
	output wire sync_o
);

	reg stage1_ff;
	reg stage2_ff;

	// ----------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stage1_ff <= 1'b0;
			stage2_ff <= 1'b0;
		end else begin
			stage1_ff <= async_i;
			stage2_ff <= stage1_ff;
		end
	end

	assign sync_o = stage2_ff;

endmodule

/* test/bctl_bus_control_one_sva.sv */
`timescale 1ns/1ps
// ----
// Port checker
// ----
module bctl_bus_control_one_sva (
	input wire clock_i,
	input wire reset_n_i,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_rvalid,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire bus_ack_i,
	input wire standby_i,
	input wire bus_released_i,
	input wire data_pins_idle_i,
	input wire address_pullup_o,
	input wire data_pullup_o,
	input wire memory_pins_drive_o,
	input wire strobe_pins_drive_o,
	input wire little_endian_o,
	input wire [14:0] burst_count_o,
	input wire area2_sdram_o,
	input wire area3_sdram_o,
	input wire memtype_prohibited_o,
	input wire area5_card_space_o,
	input wire area6_card_space_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	wire [2:0] mt = s_axi_rdata[4:2];
	wire rd = s_axi_rvalid && s_axi_rresp == 2'h0;
	function [4:0] cnt(input [1:0] c);
		cnt = (c == 2'h0) ? 5'h0 : 5'h2 << c;
	endfunction
	property p_hi; $rose(s_axi_rvalid) |-> s_axi_rdata[31:16] == 16'h0; endproperty
	a_hi: assert property (p_hi) else $error("read upper half not zero");
	property p_end; $rose(s_axi_rvalid) && rd |-> s_axi_rdata[11] == little_endian_o; endproperty
	a_end: assert property (p_end) else $error("endian flag differs");
	property p_bst; $rose(s_axi_rvalid) && rd |-> burst_count_o ==
		{cnt(s_axi_rdata[6:5]), cnt(s_axi_rdata[8:7]), cnt(s_axi_rdata[10:9])}; endproperty
	a_bst: assert property (p_bst) else $error("burst count wrong");
	property p_mt; $rose(s_axi_rvalid) && rd |-> {area2_sdram_o, area3_sdram_o,
		memtype_prohibited_o} == {mt == 3'h3, mt[2:1] == 2'h1, mt != 3'h0 && mt[2:1] != 2'h1};
	endproperty
	a_mt: assert property (p_mt) else $error("memory type decode wrong");
	property p_cs; $rose(s_axi_rvalid) && rd |->
		{area5_card_space_o, area6_card_space_o} == s_axi_rdata[1:0]; endproperty
	a_cs: assert property (p_cs) else $error("card space flags wrong");
	property p_ap; $rose(address_pullup_o) |->
		$past(bus_ack_i) ##0 address_pullup_o [*4] ##1 !address_pullup_o; endproperty
	a_ap: assert property (p_ap) else $error("address pull-up length wrong");
	property p_dp; data_pullup_o |-> $past(data_pins_idle_i); endproperty
	a_dp: assert property (p_dp) else $error("data pull-up while busy");
	property p_md; !memory_pins_drive_o |-> $past(standby_i); endproperty
	a_md: assert property (p_md) else $error("memory pins float outside standby");
	property p_sd; !strobe_pins_drive_o |-> $past(standby_i) || $past(bus_released_i);
	endproperty
	a_sd: assert property (p_sd) else $error("strobes float while bus owned");
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bh: assert property (p_bh) else $error("write answer dropped early");
endmodule
bind bctl_bus_control_one bctl_bus_control_one_sva u_sva (.*);

/* test/bctl_far_side.sv */
`timescale 1ns/1ps
// ----
// Bus side model
// ----
module bctl_far_side (
	// Clock and reset
	input wire clock_i,
	input wire reset_n_i,
	// Strap level and wanted {ack, standby, released, idle}
	input wire strap_i,
	input wire [3:0] req_i,
	// Mode pin and bus state
	output reg endian_mode_pin_o = 1'h0,
	output reg [3:0] state_o = 4'h0
);
	// strap moves only in reset, so it is steady when captured
	always @(posedge clock_i) begin
		if (!reset_n_i) begin
			endian_mode_pin_o <= strap_i;
		end
	end
	// bus state moves a cycle after the bench asks
	always @(posedge clock_i) begin
		state_o <= req_i;
	end
endmodule

/* test/bctl_bus_control_one_test.sv */
`timescale 1ns/1ps
module bctl_bus_control_one_test;
	reg clock_i = 1'h0;
	reg reset_n_i = 1'h0;
	reg [7:0] awaddr = 8'h0, araddr = 8'h0;
	reg [31:0] wdata = 32'h0;
	reg [3:0] wstrb = 4'h0, req = 4'h0;
	reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, strap = 1'h0;
	wire awready, wready, bvalid, arready, rvalid, pin, ap, dp, md, sd, le, a2, a3, mp, c5, c6;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [14:0] bc;
	wire [3:0] st;
	reg [33:0] qr[$];
	reg [1:0] qb[$];
	reg [33:0] ex;
	reg [15:0] v;
	reg [2:0] m;
	integer n_fail = 0, checked = 0, i, j, n;
	always #20 clock_i = ~clock_i;
	bctl_far_side far (.clock_i(clock_i), .reset_n_i(reset_n_i), .strap_i(strap), .req_i(req),
		.endian_mode_pin_o(pin), .state_o(st));
	bctl_bus_control_one dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.endian_mode_pin_i(pin), .bus_ack_i(st[3]), .standby_i(st[2]), .bus_released_i(st[1]),
		.data_pins_idle_i(st[0]), .address_pullup_o(ap), .data_pullup_o(dp),
		.memory_pins_drive_o(md), .strobe_pins_drive_o(sd), .little_endian_o(le),
		.burst_count_o(bc), .area2_sdram_o(a2), .area3_sdram_o(a3),
		.memtype_prohibited_o(mp), .area5_card_space_o(c5), .area6_card_space_o(c6));
	// ----
	// Tasks
	// ----
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", checked, n_fail);
			if (n_fail == 0 && checked > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task automatic chk(input [33:0] got, input [33:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tick(input integer k);
		repeat (k) @(posedge clock_i);
	endtask
	task por(input s);
		begin
			@(posedge clock_i);
			strap <= s;
			reset_n_i <= 1'h0;
			tick(2);
			reset_n_i <= 1'h1;
			tick(6);
		end
	endtask
	// One bus transfer; the expected answer is queued for the monitor
	task xfer(input w, input [7:0] a, input [15:0] d, input [3:0] s, input [33:0] e);
		reg ta, tw, seen, done;
		reg [15:0] rnd;
		integer k;
		begin
			@(posedge clock_i);
			rnd = $urandom;
			done = 1'h0;
			if (w) begin
				qb.push_back(e[33:32]);
				awaddr <= a;
				wdata <= {rnd, d};
				wstrb <= s;
				awvalid <= 1'h1;
				wvalid <= 1'h1;
				// Response ready is sometimes late, so a held answer is seen too
				bready <= rnd[0];
			end else begin
				qr.push_back(e);
				araddr <= a;
				arvalid <= 1'h1;
				rready <= 1'h1;
			end
			for (k = 0; k < 40 && !done; k = k + 1) begin
				@(negedge clock_i);
				ta = w ? awready : arready;
				tw = wready;
				seen = w ? bvalid : rvalid;
				done = seen && (w ? bready : rready);
				@(posedge clock_i);
				if (ta) begin
					awvalid <= 1'h0;
					arvalid <= 1'h0;
				end
				if (tw)
					wvalid <= 1'h0;
				if (seen && !done)
					bready <= 1'h1;
			end
			bready <= 1'h0;
			rready <= 1'h0;
			if (!done) begin
				n_fail = n_fail + 1;
				print_verdict;
			end
		end
	endtask
	always @(posedge clock_i) begin
		if (bvalid && bready)
			chk(bresp, qb.pop_front());
		if (rvalid && rready)
			chk({rresp, rdata}, qr.pop_front());
	end
	// ----
	// Scenarios
	// ----
	initial begin
		v = $urandom(32'h88d34ab3);
		por(1'h0);
		xfer(1'h0, 8'h00, 16'h0, 4'h0, 34'h0);
		for (i = 0; i < 4; i = i + 1) begin
			m = 3'(16'h5320 >> (i * 4));
			v = {4'h0, 1'h1, i[1:0], i[1:0], i[1:0], m, i[0], ~i[0]};
			xfer(1'h1, 8'h00, v, 4'hf, 34'h0);
			ex = {18'h0, v & 16'hf7ff | {4'h0, strap, 11'h0}};
			xfer(1'h0, 8'h00, 16'h0, 4'h0, ex);
			chk(bc, {3{i == 0 ? 5'h0 : 5'h2 << i}});
			chk({a2, a3, mp}, {i == 2, i == 1 || i == 2, i == 3});
			chk({c5, c6, le}, {i[0], ~i[0], strap});
		end
		// Only the low lane is enabled, and the high offset is unmapped
		ex[15:0] = ex[15:0] | 16'h00ff;
		xfer(1'h1, 8'h00, 16'h5aff, 4'h1, 34'h0);
		xfer(1'h0, 8'h00, 16'h0, 4'h0, ex);
		xfer(1'h1, 8'h04, 16'h0001, 4'hf, 34'h200000000);
		xfer(1'h0, 8'h04, 16'h0, 4'h0, 34'h200000000);
		xfer(1'h0, 8'h01, 16'h0, 4'h0, ex);
		xfer(1'h0, 8'h00, 16'h0, 4'h0, ex);
		for (j = 0; j < 2; j = j + 1) begin
			// control set before bus state moves
			xfer(1'h1, 8'h00, {{4{j[0]}}, 12'h0}, 4'hf, 34'h0);
			req <= 4'h0;
			tick(6);
			req <= 4'h8;
			n = 0;
			for (i = 0; i < 8; i = i + 1) begin
				@(negedge clock_i);
				n = n + ap;
			end
			chk(n, j * 4);
			for (i = 0; i < 24; i = i + 1) begin
				@(posedge clock_i);
				req <= (i < 16) ? i[3:0] : 4'($urandom);
				tick(2);
				@(negedge clock_i);
				chk(md, !st[2] | j[0]);
				chk(sd, !(st[2] | st[1]) | j[0]);
				chk(dp, st[0] & j[0]);
			end
		end
		por(1'h1);
		xfer(1'h0, 8'h00, 16'h0, 4'h0, 34'h800);
		chk(le, 1'h1);
		print_verdict;
	end
endmodule
